//--- adp_pkg.sv
// Constants shared by the two decimation paths.
`default_nettype none
package adp_pkg;
  // Rates
  localparam int CLOCK_HZ       = 125_000_000;
  localparam int SYS_FS_DHZ     = 421_875;
  localparam int OVERSAMPLE     = 128;
  localparam int MOD_RATE_HZ    = SYS_FS_DHZ * OVERSAMPLE / 10;
  localparam int MOD_DIV        = CLOCK_HZ / MOD_RATE_HZ;
  localparam logic [4:0] MOD_DIV_LAST = 5'(MOD_DIV - 1);
  // Decimation phase counter points
  localparam logic [3:0] PH_EIGHT_FS = 4'hF;
  localparam logic [5:0] PH_TWO_FS   = 6'h3F;
  localparam logic [6:0] PH_ONE_FS   = 7'h7F;
  // Coefficient shifts
  localparam int HP_SHIFT        = 1;
  localparam int BW_LEVEL_SHIFT  = 3;
  localparam int BW_VOICE_SHIFT  = 1;
  localparam int REHASH_SHIFT    = 2;
  localparam int DEC8_SHIFT      = 3;
  localparam int DC_SHIFT        = 8;
  // Register map and reset values
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_AUX1   = 8'h08;
  localparam logic [7:0] ADDR_AUX2   = 8'h0C;
  localparam int CTRL_U1_VOICE = 0;
  localparam int CTRL_U2_VOICE = 1;
  localparam int CTRL_U1_DC    = 2;
  localparam int CTRL_U2_DC    = 3;
  localparam int STAT_OVF      = 0;
  localparam int STAT_HOLD     = 1;
  localparam int STAT_CNT_LSB  = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Stream buffer
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
endpackage : adp_pkg
`default_nettype wire

//--- adp_top.sv
// Decimation units, sample buffer and register port.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module adp_fifo #(
  parameter int W  = 32,
  parameter int D  = 16,
  parameter int AW = 4
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        count
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } adp_fifo_st_t;

  adp_fifo_st_t s_r;
  adp_fifo_st_t s_nxt;

  // Extra pointer bit tells full from empty
  assign count     = s_r.wp - s_r.rp;
  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (s_r.wp != s_r.rp);
  assign out_data  = s_r.mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (in_valid && in_ready) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
      s_nxt.wp = s_r.wp + (AW+1)'(1);
    end
    if (out_valid && out_ready) begin
      s_nxt.rp = s_r.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : adp_fifo

////////////////////////////////////////////////////////////////////////////////
module adp_unit
  import adp_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               aux_bit,
  input  wire logic               aud_bit,
  input  wire logic               voice_select,
  input  wire logic               dc_filter_enable,
  output logic signed [15:0]      aux_data,
  output logic                    aux_valid,
  output logic signed [15:0]      ifd_data,
  output logic                    ifd_valid,
  output logic signed [15:0]      aud_data,
  output logic                    aud_valid
);
  typedef struct packed {
    logic        [6:0]  cnt;
    logic signed [15:0] ai1;
    logic signed [15:0] ai2;
    logic signed [15:0] bc1;
    logic signed [15:0] bc2;
    logic signed [15:0] hx;
    logic signed [15:0] hy;
    logic signed [15:0] ac1;
    logic signed [15:0] ac2;
    logic signed [15:0] cx1;
    logic signed [15:0] cx2;
    logic signed [15:0] bw;
    logic signed [15:0] di1;
    logic signed [15:0] di2;
    logic signed [15:0] di3;
    logic signed [15:0] dc1;
    logic signed [15:0] dc2;
    logic signed [15:0] dc3;
    logic signed [18:0] acc;
    logic signed [23:0] dcest;
    logic signed [15:0] aux_out;
    logic               aux_vld;
    logic signed [15:0] ifd_out;
    logic               ifd_vld;
    logic signed [15:0] aud_out;
    logic               aud_vld;
  } adp_unit_st_t;

  adp_unit_st_t s_r;
  adp_unit_st_t s_nxt;

  logic signed [15:0] in_aux;
  logic signed [15:0] in_aud;
  logic signed [15:0] br_a;
  logic signed [15:0] br_b;
  logic signed [16:0] hp_sum;
  logic signed [15:0] hp_out;
  logic signed [15:0] ac_a;
  logic signed [15:0] ac_b;
  logic signed [17:0] comp_w;
  logic signed [15:0] comp;
  logic signed [16:0] bw_d;
  logic signed [16:0] bw_w;
  logic signed [15:0] ad_a;
  logic signed [15:0] ad_b;
  logic signed [15:0] ad_c;
  logic signed [15:0] rehash;
  logic signed [18:0] acc_sum;
  logic signed [15:0] avg;
  logic signed [17:0] gain_w;
  logic signed [23:0] dc_w;
  logic signed [17:0] dc_out;

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07FFF) begin
      sat16 = 16'sh7FFF;
    end else if (v < -18'sh08000) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  assign in_aux  = aux_bit ? 16'sh0001 : 16'shFFFF;
  assign in_aud  = aud_bit ? 16'sh0001 : 16'shFFFF;

  // branch comb at eight times fs
  assign br_a    = s_r.ai2 - s_r.bc1;
  assign br_b    = br_a - s_r.bc2;
  // first-order high-pass, pole at one half
  assign hp_sum  = 17'(s_r.hy) + 17'(br_b) - 17'(s_r.hx);
  assign hp_out  = 16'(hp_sum >>> HP_SHIFT);

  assign ac_a    = s_r.ai2 - s_r.ac1;
  assign ac_b    = ac_a - s_r.ac2;
  // droop boost: 1.25 x minus an eighth of the two older taps
  assign comp_w  = 18'(ac_b) + 18'(ac_b >>> 2) - ((18'(s_r.cx1) + 18'(s_r.cx2)) >>> 3);
  assign comp    = sat16(comp_w);
  assign bw_d    = 17'(comp) - 17'(s_r.bw);
  // voice coefficient when select is 1
  assign bw_w    = 17'(s_r.bw) + (voice_select ? (bw_d >>> BW_VOICE_SHIFT) : (bw_d >>> BW_LEVEL_SHIFT));

  // third-order comb for the one-bit audio stream
  assign ad_a    = s_r.di3 - s_r.dc1;
  assign ad_b    = ad_a - s_r.dc2;
  assign ad_c    = ad_b - s_r.dc3;
  // rehash to full scale before the second decimator
  assign rehash  = ad_c <<< REHASH_SHIFT;
  assign acc_sum = s_r.acc + 19'(rehash);
  assign avg     = 16'(acc_sum >>> DEC8_SHIFT);
  // passband gain of 1.75, about 4.86 dB
  assign gain_w  = 18'(avg) + 18'(avg >>> 1) + 18'(avg >>> 2);
  // running DC estimate scaled by 256
  assign dc_w    = s_r.dcest + 24'(gain_w) - (s_r.dcest >>> DC_SHIFT);
  assign dc_out  = gain_w - 18'(s_r.dcest >>> DC_SHIFT);

  always_comb begin
    s_nxt = s_r;
    s_nxt.aux_vld = 1'b0;
    s_nxt.ifd_vld = 1'b0;
    s_nxt.aud_vld = 1'b0;
    if (ce) begin
      s_nxt.cnt = s_r.cnt + 7'h01;
      // two cascaded integrators on aux and three on audio, wrapping by design
      s_nxt.ai1 = s_r.ai1 + in_aux;
      s_nxt.ai2 = s_r.ai2 + s_r.ai1;
      s_nxt.di1 = s_r.di1 + in_aud;
      s_nxt.di2 = s_r.di2 + s_r.di1;
      s_nxt.di3 = s_r.di3 + s_r.di2;
      if (s_r.cnt[3:0] == PH_EIGHT_FS) begin
        s_nxt.bc1     = s_r.ai2;
        s_nxt.bc2     = br_a;
        s_nxt.hx      = br_b;
        s_nxt.hy      = hp_out;
        s_nxt.ifd_out = hp_out;
        s_nxt.ifd_vld = 1'b1;
        s_nxt.dc1     = s_r.di3;
        s_nxt.dc2     = ad_a;
        s_nxt.dc3     = ad_b;
        s_nxt.acc     = acc_sum;
      end
      if (s_r.cnt[5:0] == PH_TWO_FS) begin
        // decimate by 64 to twice fs
        s_nxt.ac1     = s_r.ai2;
        s_nxt.ac2     = ac_a;
        s_nxt.cx1     = ac_b;
        s_nxt.cx2     = s_r.cx1;
        s_nxt.bw      = 16'(bw_w);
        s_nxt.aux_out = 16'(bw_w);
        s_nxt.aux_vld = 1'b1;
      end
      if (s_r.cnt == PH_ONE_FS) begin
        s_nxt.acc     = '0;
        s_nxt.dcest   = dc_w;
        s_nxt.aud_out = dc_filter_enable ? sat16(dc_out) : sat16(gain_w);
        s_nxt.aud_vld = 1'b1;
      end
    end
  end

  // integrators start from zero, so the first outputs carry a transient
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign aux_data  = s_r.aux_out;
  assign aux_valid = s_r.aux_vld;
  assign ifd_data  = s_r.ifd_out;
  assign ifd_valid = s_r.ifd_vld;
  assign aud_data  = s_r.aud_out;
  assign aud_valid = s_r.aud_vld;
endmodule : adp_unit

////////////////////////////////////////////////////////////////////////////////
module adp_top
  import adp_pkg::*;
(
  input  wire logic          CLOCK,
  input  wire logic          RST_N,
  input  wire logic          U1_AUX_BIT,
  input  wire logic          U1_AUD_BIT,
  input  wire logic          U2_AUX_BIT,
  input  wire logic          U2_AUD_BIT,
  input  wire logic [7:0]    REG_ADDR,
  input  wire logic [31:0]   REG_WDATA,
  input  wire logic          REG_WR,
  input  wire logic          REG_RD,
  output logic [31:0]        REG_RDATA,
  output logic [15:0]        U1_AUX_DATA,
  output logic               U1_AUX_VALID,
  output logic [15:0]        U2_AUX_DATA,
  output logic               U2_AUX_VALID,
  output logic [15:0]        U1_IFD_DATA,
  output logic               U1_IFD_VALID,
  output logic [15:0]        U2_IFD_DATA,
  output logic               U2_IFD_VALID,
  output logic [31:0]        AUDIO_DATA,
  output logic               AUDIO_VALID,
  input  wire logic          AUDIO_READY
);
  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [4:0]  div;
    logic        ce;
    logic [3:0]  ctrl;
    logic        ovf;
    logic [31:0] hold;
    logic        hold_vld;
    logic [31:0] out_data;
    logic        out_vld;
    logic [31:0] rdata;
  } adp_top_st_t;

  adp_top_st_t s_r;
  adp_top_st_t s_nxt;

  logic signed [15:0] u1_aud;
  logic signed [15:0] u2_aud;
  logic               u1_aud_vld;
  logic               u2_aud_vld;
  logic signed [15:0] u1_aux;
  logic signed [15:0] u2_aux;
  logic signed [15:0] u1_ifd;
  logic signed [15:0] u2_ifd;
  logic               f_in_ready;
  logic               f_out_valid;
  logic [31:0]        f_out_data;
  logic [FIFO_AW:0]   f_count;
  logic               pop;

  // Both units share one enable, so their audio samples land in the same cycle
  assign pop = f_out_valid && (!s_r.out_vld || AUDIO_READY);

  always_comb begin
    s_nxt = s_r;
    // Modulator bits come in as pins
    s_nxt.sync1 = {U2_AUD_BIT, U2_AUX_BIT, U1_AUD_BIT, U1_AUX_BIT};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.ce  = (s_r.div == MOD_DIV_LAST);
    s_nxt.div = (s_r.div == MOD_DIV_LAST) ? 5'h00 : s_r.div + 5'h01;
    // Holding word drains into the buffer; a sample meeting a full hold that cannot drain is lost
    if (s_r.hold_vld && f_in_ready) begin
      s_nxt.hold_vld = 1'b0;
    end
    if (REG_WR && REG_ADDR == ADDR_STATUS && REG_WDATA[STAT_OVF]) begin
      s_nxt.ovf = 1'b0;
    end
    if (u1_aud_vld) begin
      if (s_r.hold_vld && !f_in_ready) begin
        s_nxt.ovf = 1'b1;
      end else begin
        s_nxt.hold     = {u2_aud, u1_aud};
        s_nxt.hold_vld = 1'b1;
      end
    end
    // Output register decouples the port from buffer memory
    if (pop) begin
      s_nxt.out_data = f_out_data;
      s_nxt.out_vld  = 1'b1;
    end else if (AUDIO_READY) begin
      s_nxt.out_vld  = 1'b0;
    end
    // per-unit select bits held in the control word
    if (REG_WR && REG_ADDR == ADDR_CTRL) begin
      s_nxt.ctrl = REG_WDATA[3:0];
    end
    s_nxt.rdata = 32'h0000_0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_CTRL:   s_nxt.rdata = {28'h000_0000, s_r.ctrl};
        ADDR_STATUS: s_nxt.rdata = {23'h00_0000, f_count, 2'h0, s_r.hold_vld, s_r.ovf};
        ADDR_AUX1:   s_nxt.rdata = {{16{u1_aux[15]}}, u1_aux};
        ADDR_AUX2:   s_nxt.rdata = {{16{u2_aux[15]}}, u2_aux};
        default:     s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_r      <= '0;
      s_r.ctrl <= CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  adp_unit u_unit1 (
    .clk              (CLOCK),
    .rst_n            (RST_N),
    .ce               (s_r.ce),
    .aux_bit          (s_r.sync2[0]),
    .aud_bit          (s_r.sync2[1]),
    .voice_select     (s_r.ctrl[CTRL_U1_VOICE]),
    .dc_filter_enable (s_r.ctrl[CTRL_U1_DC]),
    .aux_data         (u1_aux),
    .aux_valid        (U1_AUX_VALID),
    .ifd_data         (u1_ifd),
    .ifd_valid        (U1_IFD_VALID),
    .aud_data         (u1_aud),
    .aud_valid        (u1_aud_vld)
  );

  adp_unit u_unit2 (
    .clk              (CLOCK),
    .rst_n            (RST_N),
    .ce               (s_r.ce),
    .aux_bit          (s_r.sync2[2]),
    .aud_bit          (s_r.sync2[3]),
    .voice_select     (s_r.ctrl[CTRL_U2_VOICE]),
    .dc_filter_enable (s_r.ctrl[CTRL_U2_DC]),
    .aux_data         (u2_aux),
    .aux_valid        (U2_AUX_VALID),
    .ifd_data         (u2_ifd),
    .ifd_valid        (U2_IFD_VALID),
    .aud_data         (u2_aud),
    .aud_valid        (u2_aud_vld)
  );

  adp_fifo #(
    .W  (FIFO_WIDTH),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .in_valid  (s_r.hold_vld),
    .in_ready  (f_in_ready),
    .in_data   (s_r.hold),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data),
    .count     (f_count)
  );

  assign REG_RDATA   = s_r.rdata;
  assign U1_AUX_DATA = u1_aux;
  assign U2_AUX_DATA = u2_aux;
  assign U1_IFD_DATA = u1_ifd;
  assign U2_IFD_DATA = u2_ifd;
  assign AUDIO_DATA  = s_r.out_data;
  assign AUDIO_VALID = s_r.out_vld;
endmodule : adp_top
`default_nettype wire

//--- adp_modulator.sv
// Behavioural sigma-delta modulator feeding both decimation paths.
`default_nettype none
module adp_modulator
  import adp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic signed [7:0] level,
  output logic                   aux_bit,
  output logic                   aud_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [9:0] acc_r;
  logic [4:0]        div_r;
  ////////////////////////////////////////////////////////////////////////////////
  // first-order loop at 128 fs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 10'sh000;
      div_r <= 5'h00;
    end else begin
      div_r <= (div_r == MOD_DIV_LAST) ? 5'h00 : div_r + 5'h01;
      if (div_r == MOD_DIV_LAST) begin
        acc_r <= acc_r + level - (aux_bit ? 10'sh040 : -10'sh040);
      end
    end
  end
  // Same stream on both paths so twin units must agree
  assign aux_bit = ~acc_r[9];
  assign aud_bit = ~acc_r[9];
endmodule // adp_modulator
`default_nettype wire

//--- adp_top_monitor.sv
// Assertion checker bound to the decimation top level.
`default_nettype none
module adp_monitor
  import adp_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [15:0] U1_AUX_DATA,
  input wire logic        U1_AUX_VALID,
  input wire logic        U2_AUX_VALID,
  input wire logic        U1_IFD_VALID,
  input wire logic        U2_IFD_VALID,
  input wire logic [31:0] AUDIO_DATA,
  input wire logic        AUDIO_VALID,
  input wire logic        AUDIO_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [11:0] aux_gap_r;
  logic [8:0]  ifd_gap_r;
  logic        aux_seen_r;
  logic        ifd_seen_r;
  // Gaps count clocks since the cycle after the previous pulse
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aux_gap_r  <= 12'h000;
      ifd_gap_r  <= 9'h000;
      aux_seen_r <= 1'b0;
      ifd_seen_r <= 1'b0;
    end else begin
      aux_gap_r  <= U1_AUX_VALID ? 12'h000 : aux_gap_r + 12'h001;
      ifd_gap_r  <= U1_IFD_VALID ? 9'h000 : ifd_gap_r + 9'h001;
      aux_seen_r <= aux_seen_r | U1_AUX_VALID;
      ifd_seen_r <= ifd_seen_r | U1_IFD_VALID;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_aux_period: assert property (U1_AUX_VALID && aux_seen_r |-> aux_gap_r == 12'h5BF)
    else $error("aux sample spacing wrong");
  a_ifd_period: assert property (U1_IFD_VALID && ifd_seen_r |-> ifd_gap_r == 9'h16F)
    else $error("branch sample spacing wrong");
  a_aux_twins: assert property (U1_AUX_VALID == U2_AUX_VALID)
    else $error("aux pulses of the units differ");
  a_ifd_twins: assert property (U1_IFD_VALID == U2_IFD_VALID)
    else $error("branch pulses of the units differ");
  a_audio_hold: assert property (AUDIO_VALID && !AUDIO_READY |=> AUDIO_VALID && $stable(AUDIO_DATA))
    else $error("audio word dropped while stalled");
  a_reset_quiet: assert property ($rose(RST_N) |-> !AUDIO_VALID && !U1_AUX_VALID && REG_RDATA == 32'h0)
    else $error("outputs not quiet after reset");
  a_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside read slot");
  a_aux_mirror: assert property ($past(REG_RD) && $past(REG_ADDR) == ADDR_AUX1 |->
    REG_RDATA == {{16{$past(U1_AUX_DATA[15])}}, $past(U1_AUX_DATA)})
    else $error("aux register differs from aux output");
  c_audio_taken: cover property (AUDIO_VALID && AUDIO_READY);
  c_audio_stall: cover property (AUDIO_VALID && !AUDIO_READY);
  c_aux_pulse: cover property (U1_AUX_VALID && aux_seen_r);
endmodule // adp_monitor
bind adp_top adp_monitor adp_monitor_inst (.CLOCK, .RST_N, .REG_ADDR, .REG_RD, .REG_RDATA, .U1_AUX_DATA,
  .U1_AUX_VALID, .U2_AUX_VALID, .U1_IFD_VALID, .U2_IFD_VALID, .AUDIO_DATA, .AUDIO_VALID, .AUDIO_READY);
`default_nettype wire

//--- adp_top_bench.sv
// Self-checking bench for the decimation top level.
`default_nettype none
module adp_top_bench;
  import adp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst_n, reg_wr, reg_rd, aud_rdy, aud_valid, u1_av, m_aux, m_aud;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, aud_data, rd, a1;
  logic signed [7:0] level;
  int                n_fail, checks, cyc, t0, i;

  adp_modulator adp_modulator_inst (.clk(clk), .rst_n(rst_n), .level(level), .aux_bit(m_aux), .aud_bit(m_aud));
  adp_top adp_top_inst (.CLOCK(clk), .RST_N(rst_n), .U1_AUX_BIT(m_aux), .U1_AUD_BIT(m_aud),
    .U2_AUX_BIT(m_aux), .U2_AUD_BIT(m_aud), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .U1_AUX_DATA(), .U1_AUX_VALID(u1_av),
    .U2_AUX_DATA(), .U2_AUX_VALID(), .U1_IFD_DATA(), .U1_IFD_VALID(), .U2_IFD_DATA(),
    .U2_IFD_VALID(), .AUDIO_DATA(aud_data), .AUDIO_VALID(aud_valid), .AUDIO_READY(aud_rdy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Data is looked at only in the single cycle after the strobe
  task automatic reg_read(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Bounded waits; an exhausted bound closes the run
  task automatic wait_aux(input int n);
    int lim;
    // Bound fixed up front, since n counts down
    lim = n * 1600;
    for (int k = 0; k < lim && n > 0; k++) begin
      @(posedge clk);
      if (u1_av === 1'b1) n--;
    end
    if (n > 0) begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic wait_aud;
    int k;
    for (k = 0; k < 4000; k++) begin
      @(posedge clk);
      if (aud_valid === 1'b1 && aud_rdy === 1'b1) break;
    end
    if (k == 4000) begin
      n_fail++;
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    // Sink ready from the start so no backlog skews the spacing check
    aud_rdy = 1'b1; level = 8'sh28;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(ADDR_CTRL); check(rd, 32'h0);
    reg_write(8'h10, 32'hF);
    reg_read(8'h10); check(rd, 32'h0);
    reg_read(ADDR_CTRL); check(rd, 32'h0);
    for (i = 0; i < 16; i++) begin
      reg_write(ADDR_CTRL, 32'(i));
      reg_read(ADDR_CTRL); check(rd, 32'(i));
    end
    // Same stream and settings: twin units agree
    reg_write(ADDR_CTRL, 32'h0);
    wait_aux(4);
    reg_read(ADDR_AUX1); a1 = rd;
    reg_read(ADDR_AUX2); check(rd, a1);
    // Step after selecting voice on unit 1 only
    reg_write(ADDR_CTRL, 32'h1);
    level <= -8'sh28;
    wait_aux(4);
    reg_read(ADDR_AUX1); a1 = rd;
    reg_read(ADDR_AUX2); check({31'h0, rd !== a1}, 32'h1);
    // Audio spacing and twin halves
    reg_write(ADDR_CTRL, 32'h0);
    aud_rdy <= 1'b1;
    repeat (3) wait_aud();
    t0 = cyc;
    wait_aud();
    check(32'(cyc - t0), 32'(OVERSAMPLE * MOD_DIV));
    check({16'h0, aud_data[31:16]}, {16'h0, aud_data[15:0]});
    // DC removal on unit 1 only pulls its half away
    reg_write(ADDR_CTRL, 32'h4);
    repeat (3) wait_aud();
    check({31'h0, aud_data[31:16] !== aud_data[15:0]}, 32'h1);
    // Stall the sink until the buffer refuses
    aud_rdy <= 1'b0;
    rd = 32'h0;
    for (i = 0; i < 700 && rd[0] !== 1'b1; i++) begin
      repeat (100) @(posedge clk);
      reg_read(ADDR_STATUS);
    end
    check(rd & 32'h1F3, 32'h103);
    // Drain: count empties, overflow stays until cleared
    aud_rdy <= 1'b1;
    repeat (60) @(posedge clk);
    reg_read(ADDR_STATUS); check(rd, 32'h1);
    reg_write(ADDR_STATUS, 32'h1);
    reg_read(ADDR_STATUS); check(rd, 32'h0);
    test_done();
  end
endmodule // adp_top_bench
`default_nettype wire
